/* rtl/pocu_pkg.sv */
// Shared constants, types and register map for the pulse output command unit
package pocu_pkg;
    // ------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int CYC_PER_PCT = CLK_HZ / 100;
    localparam logic [3:0] CMD_LAT_CYC = 4'h4;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FREQ = 8'h04;
    localparam logic [7:0] OFS_DUTY = 8'h08;
    localparam logic [7:0] OFS_LIMIT = 8'h0C;
    localparam logic [7:0] OFS_FUNC = 8'h10;
    localparam logic [7:0] OFS_POS = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;
    localparam logic [7:0] OFS_RESULT = 8'h1C;
    localparam logic [7:0] OFS_LCFG = 8'h20;
    // ------------------------------------------------------------
    // Field positions, reset values, duty default and range limits
    // ------------------------------------------------------------
    localparam int CTRL_RDERR = 0;
    localparam int CTRL_RTLM = 1;
    localparam int CTRL_RTPM = 2;
    localparam int CTRL_CHAN_LSB = 8;
    localparam int CTRL_MOD_LSB = 16;
    localparam int CTRL_REMOTE = 24;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] FREQ_RST = 16'h03E8;
    localparam logic [15:0] FREQ_MIN = 16'h0014;
    localparam logic [15:0] FREQ_MAX = 16'h4E20;
    localparam logic [7:0] DUTY_DEF = 8'h32;
    localparam logic [7:0] DUTY_MAX = 8'h63;
    localparam logic [31:0] POS_MAX = 32'h7FFF_4020;
    // ------------------------------------------------------------
    // Error codes
    // ------------------------------------------------------------
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_BAD_CMD = 16'h0064;
    localparam logic [15:0] ERR_NO_FILE = 16'h0065;
    localparam logic [15:0] ERR_FILE_TYPE = 16'h0066;
    localparam logic [15:0] ERR_PROFILE = 16'h0067;
    localparam logic [15:0] ERR_NOT_LIMIT = 16'h0068;
    localparam logic [15:0] ERR_EDGE_RANGE = 16'h0069;
    localparam logic [15:0] ERR_FUNC_BAD = 16'h006A;
    localparam logic [15:0] ERR_FUNC_RANGE = 16'h006B;
    localparam logic [15:0] ERR_PRESET_FN = 16'h006C;
    localparam logic [15:0] ERR_TABLE_FULL = 16'h006D;
    localparam logic [15:0] ERR_ENTRY_RANGE = 16'h006E;
    localparam logic [15:0] ERR_REG_RANGE = 16'h006F;
    localparam logic [15:0] ERR_REG_UNCFG = 16'h0070;
    localparam logic [15:0] ERR_REMOTE = 16'h07D1;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_FINISH = 2'h3
    } pocu_state_type;
    typedef struct packed {
        logic [1:0] chan;
        logic pos_mode;
        logic [15:0] freq;
        logic [7:0] duty;
        logic [7:0] limit;
        logic [7:0] func;
        logic [31:0] pos;
    } pocu_param_type;
endpackage

/* rtl/pocu_top.sv */
// Command unit: read-error, run-to-limit and run-to-position over AHB-Lite
// Functional notes
// [R01] Read-error copies retained code into result
// [R02] Retained code is lost on next command
// [R03] Controller reads error right after failure
// [R04] Codes 0 and 100 to 103
// [R05] Codes 104 to 107 for limit inputs
// [R06] Codes 108 to 112 for presets and registers
// [R07] Remote base read-error reports 2001
// [R08] Run-to-limit loads frequency, limit, duty
// [R09] Controller configures limit inputs first
// [R10] Limit byte: edge digit, input digit
// [R11] Pulse until chosen limit edge occurs
// [R12] Multi-cycle; exactly one of success/error
// [R13] Frequency in hertz, 20 to 20000
// [R14] Duty 0..99, zero means fifty percent
// [R15] Run-to-position loads frequency, duty, function, position
// [R16] Function byte: test digit, source digit
// [R17] Stop when count meets position; range checked
// [R18] Module number 0..255, channels 0..3
// [R19] Controller keeps scratch word private
// [R20] Start on rising enable; flags hold
//
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module pocu_top import pocu_pkg::*; #(
    parameter logic [7:0] MODULE_NUM = 8'h01
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [3:0] limit_in,
    input wire logic [3:0][31:0] count_in,
    output logic [3:0] pulse_out
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    // Bus data-phase bookkeeping
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [7:0] addr_reg;
    logic hready_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] rd_next;
    // Software registers
    logic [31:0] ctrl_reg;
    logic [15:0] freq_reg;
    logic [7:0] duty_reg;
    logic [7:0] limit_reg;
    logic [7:0] func_reg;
    logic [31:0] pos_reg;
    logic [3:0] lcfg_reg;
    // Command sequencer
    pocu_state_type state_reg;
    logic [3:0] wait_reg;
    logic [2:0] en_prev_reg;
    logic [2:0] en_rise;
    logic [2:0] cmd_reg;
    logic [15:0] code_reg;
    logic [15:0] err_code_reg;
    logic [15:0] result_reg;
    logic success_reg;
    logic error_reg;
    pocu_param_type par_reg;
    pocu_param_type act_reg;
    // Pulse generator
    logic run_reg;
    logic [24:0] phase_reg;
    logic [24:0] phase_sum;
    logic [24:0] thresh;
    logic [7:0] duty_eff;
    logic [3:0] pulse_reg;
    logic stop_hit;
    // Limit input conditioning
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] sync3_reg;
    logic [3:0] stable_reg;
    logic [3:0] stable_d_reg;
    logic [3:0] lim_rise;
    logic [3:0] lim_fall;

    assign hreadyout = hready_reg;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign pulse_out = pulse_reg;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Parameter check; first failing field wins
    function automatic logic [15:0] check_code(
        input logic [2:0] cmd,
        input logic [31:0] ctrl,
        input pocu_param_type p,
        input logic [3:0] lcfg
    );
        logic [15:0] c;
        c = ERR_NONE;
        if (ctrl[CTRL_MOD_LSB +: 8] != MODULE_NUM) begin
            c = ERR_BAD_CMD; // R18
        end else if (cmd[CTRL_RDERR]) begin
            c = ctrl[CTRL_REMOTE] ? ERR_REMOTE : ERR_NONE; // R07
        end else if (p.freq < FREQ_MIN || p.freq > FREQ_MAX) begin
            c = ERR_REG_RANGE; // R13
        end else if (p.duty > DUTY_MAX) begin
            c = ERR_REG_RANGE; // R14
        end else if (cmd[CTRL_RTLM]) begin
            if (p.limit[3:0] > 4'h3) begin
                c = ERR_FUNC_RANGE; // R05
            end else if (p.limit[7:4] > 4'h2) begin
                c = ERR_EDGE_RANGE; // R10
            end else if (!lcfg[p.limit[1:0]]) begin
                c = ERR_NOT_LIMIT; // R05
            end
        end else begin
            if (p.func[7:4] > 4'h1) begin
                c = ERR_FUNC_BAD; // R16
            end else if (p.func[3:0] > 4'h3) begin
                c = ERR_FUNC_RANGE; // R16
            end else if (p.pos > POS_MAX) begin
                c = ERR_REG_RANGE; // R17
            end
        end
        return c;
    endfunction

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    // Writes finish with no wait; reads take one wait state so the
    // read word always reflects a write that just went before it
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
            hready_reg <= 1'b1;
        end else begin
            wr_pend_reg <= 1'b0;
            if (rd_pend_reg) begin
                // Read data is out now
                rd_pend_reg <= 1'b0;
                hready_reg <= 1'b1;
            end else if (hsel && htrans[1] && hready) begin
                // Address phase taken
                addr_reg <= haddr[7:0];
                wr_pend_reg <= hwrite;
                rd_pend_reg <= !hwrite;
                hready_reg <= hwrite;
            end
        end
    end

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        rd_next = 32'h0000_0000;
        case (addr_reg)
            OFS_CTRL: rd_next = ctrl_reg;
            OFS_FREQ: rd_next = {16'h0000, freq_reg};
            OFS_DUTY: rd_next = {24'h000000, duty_reg};
            OFS_LIMIT: rd_next = {24'h000000, limit_reg};
            OFS_FUNC: rd_next = {24'h000000, func_reg};
            OFS_POS: rd_next = pos_reg;
            OFS_STAT: begin
                rd_next = {24'h000000, act_reg.chan, 1'b0, run_reg,
                           state_reg != ST_IDLE, error_reg, success_reg,
                           1'b0};
            end
            OFS_RESULT: rd_next = {16'h0000, result_reg};
            OFS_LCFG: rd_next = {28'h0000000, lcfg_reg};
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // Read data register
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (rd_pend_reg) begin
            hrdata_reg <= rd_next;
        end
    end

    // Register writes in the data phase
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl_reg <= CTRL_RST;
            freq_reg <= FREQ_RST;
            duty_reg <= 8'h00;
            limit_reg <= 8'h00;
            func_reg <= 8'h00;
            pos_reg <= 32'h0000_0000;
            lcfg_reg <= 4'h0;
        end else if (wr_pend_reg) begin
            case (addr_reg)
                OFS_CTRL: ctrl_reg <= hwdata;
                OFS_FREQ: freq_reg <= hwdata[15:0];
                OFS_DUTY: duty_reg <= hwdata[7:0];
                OFS_LIMIT: limit_reg <= hwdata[7:0];
                OFS_FUNC: func_reg <= hwdata[7:0];
                OFS_POS: pos_reg <= hwdata;
                OFS_LCFG: lcfg_reg <= hwdata[3:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    // Only a fresh rising enable starts a command
    assign en_rise = ctrl_reg[2:0] & ~en_prev_reg; // R20

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            en_prev_reg <= 3'h0;
        end else begin
            en_prev_reg <= ctrl_reg[2:0];
        end
    end

    // Trigger, latency count, then result. Triggers while busy are
    // dropped: the controller holds a single command at a time.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            wait_reg <= 4'h0;
            cmd_reg <= 3'h0;
            code_reg <= ERR_NONE;
            err_code_reg <= ERR_NONE;
            result_reg <= 16'h0000;
            success_reg <= 1'b0;
            error_reg <= 1'b0;
            par_reg <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (en_rise != 3'h0) begin
                        // Lowest enable bit has priority
                        if (en_rise[CTRL_RDERR]) begin
                            cmd_reg <= 3'h1;
                        end else if (en_rise[CTRL_RTLM]) begin
                            cmd_reg <= 3'h2;
                        end else begin
                            cmd_reg <= 3'h4;
                        end
                        // Snapshot of the parameters
                        par_reg.chan <= ctrl_reg[CTRL_CHAN_LSB +: 2]; // R18
                        par_reg.pos_mode <= !en_rise[CTRL_RTLM]; // R08 R15
                        par_reg.freq <= freq_reg; // R13
                        par_reg.duty <= duty_reg; // R14
                        par_reg.limit <= limit_reg; // R08
                        par_reg.func <= func_reg; // R15
                        par_reg.pos <= pos_reg; // R15
                        // Result word: retained code or remote answer
                        if (en_rise[CTRL_RDERR]) begin
                            result_reg <= ctrl_reg[CTRL_REMOTE] ? ERR_REMOTE
                                                                : err_code_reg; // R01 R07
                        end
                        err_code_reg <= ERR_NONE; // R02
                        success_reg <= 1'b0; // R20
                        error_reg <= 1'b0; // R20
                        wait_reg <= CMD_LAT_CYC; // R12
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // Parameters are checked while the latency runs
                    code_reg <= check_code(cmd_reg, ctrl_reg, par_reg,
                                           lcfg_reg); // R04 R05 R06
                    if (wait_reg == 4'h0) begin
                        state_reg <= ST_FINISH;
                    end else begin
                        wait_reg <= wait_reg - 4'h1;
                    end
                end
                ST_FINISH: begin
                    // Exactly one flag; both hold until the next start
                    success_reg <= (code_reg == ERR_NONE); // R12
                    error_reg <= (code_reg != ERR_NONE); // R12
                    err_code_reg <= code_reg; // R02
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Limit input synchronisers
    // ------------------------------------------------------------
    // A level counts once stages two and three agree, which also
    // rejects a single-cycle glitch on the pin
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            sync3_reg <= 4'h0;
            stable_reg <= 4'h0;
            stable_d_reg <= 4'h0;
        end else begin
            sync1_reg <= limit_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            stable_reg <= (sync2_reg & ~(sync2_reg ^ sync3_reg))
                        | (stable_reg & (sync2_reg ^ sync3_reg));
            stable_d_reg <= stable_reg;
        end
    end

    assign lim_rise = stable_reg & ~stable_d_reg;
    assign lim_fall = ~stable_reg & stable_d_reg;

    // ------------------------------------------------------------
    // Stop condition
    // ------------------------------------------------------------
    always_comb begin
        stop_hit = 1'b0;
        if (act_reg.pos_mode) begin
            // Test digit 1 is greater-than, 0 is less-than
            if (act_reg.func[4]) begin
                stop_hit = count_in[act_reg.func[1:0]] > act_reg.pos; // R16 R17
            end else begin
                stop_hit = count_in[act_reg.func[1:0]] < act_reg.pos; // R16 R17
            end
        end else begin
            case (act_reg.limit[5:4])
                2'h0: stop_hit = lim_rise[act_reg.limit[1:0]]; // R10 R11
                2'h1: stop_hit = lim_fall[act_reg.limit[1:0]]; // R10 R11
                default: begin
                    stop_hit = lim_rise[act_reg.limit[1:0]]
                             | lim_fall[act_reg.limit[1:0]]; // R10 R11
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pulse generator
    // ------------------------------------------------------------
    // Phase accumulator modulo the clock rate: the average rate is
    // exact in hertz at the cost of one clock of edge jitter
    assign duty_eff = (act_reg.duty == 8'h00) ? DUTY_DEF : act_reg.duty; // R14
    assign thresh = 25'(duty_eff * CYC_PER_PCT); // R14
    assign phase_sum = phase_reg + {9'h000, act_reg.freq}; // R13

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            run_reg <= 1'b0;
            act_reg <= '0;
        end else if (state_reg == ST_FINISH && code_reg == ERR_NONE
                     && !cmd_reg[CTRL_RDERR]) begin
            // Load the command into the channel and start pulsing
            act_reg <= par_reg; // R08 R15
            run_reg <= 1'b1; // R11
        end else if (run_reg && stop_hit) begin
            run_reg <= 1'b0; // R11 R17
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn || !run_reg) begin
            phase_reg <= 25'h0000000;
        end else if (phase_sum >= 25'(CLK_HZ)) begin
            phase_reg <= phase_sum - 25'(CLK_HZ);
        end else begin
            phase_reg <= phase_sum;
        end
    end

    // One output per channel; only the loaded channel toggles
    generate
        for (genvar i = 0; i < 4; i++) begin : g_out
            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    pulse_reg[i] <= 1'b0;
                end else begin
                    pulse_reg[i] <= run_reg && !stop_hit
                                  && (act_reg.chan == 2'(i))
                                  && (phase_reg < thresh); // R11 R18
                end
            end
        end
    endgenerate

    // hsize is not decoded: every transfer is served as a whole-word transfer
endmodule

/* test/pocu_props.sv */
// Bus timing and reset checks of the command unit
`timescale 1ns/1ps
module pocu_props import pocu_pkg::*; (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [3:0] pulse_out
);
    // ----------------------------------------
    // Requests and answers
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    logic rd_seen; // A read was taken at the last edge
    // Accepted read, for tracing a wait state
    always_ff @(posedge ref_clk) begin
        rd_seen <= rstn && hsel && htrans[1] && !hwrite && hready;
    end
    sequence rd_req;
        hsel && htrans[1] && !hwrite && hready;
    endsequence
    sequence wr_req;
        hsel && htrans[1] && hwrite && hready;
    endsequence
    // One wait cycle, then data
    sequence rd_ans;
        !hreadyout ##1 hreadyout;
    endsequence
    AST_RD_WAIT: assert property (rd_req |=> rd_ans)
        else $error("read wait state not one cycle");
    AST_WR_NOWAIT: assert property (wr_req |=> hreadyout)
        else $error("write stalled the bus");
    AST_LOW_ONE: assert property (!hreadyout |=> hreadyout)
        else $error("wait state longer than one cycle");
    AST_LOW_CAUSE: assert property ($fell(hreadyout) |-> rd_seen)
        else $error("wait state without a read");
    AST_DATA_HOLD: assert property (!$stable(hrdata) |-> $rose(hreadyout))
        else $error("read data changed outside an answer");
    AST_RESP_OKAY: assert property (hresp == 1'b0)
        else $error("error response seen");
    AST_RST_BUS: assert property ($rose(rstn) |-> hreadyout && hrdata == 32'h0)
        else $error("bus outputs not at reset values");
    // No command can complete within eight cycles of release
    AST_RST_QUIET: assert property ($rose(rstn) |-> (pulse_out == 4'h0) [*8])
        else $error("pulse output active after reset");
endmodule
bind pocu_top pocu_props pocu_props_inst (
    .ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pulse_out(pulse_out));

/* test/pocu_field_model.sv */
// Field side: encoder counting output pulses and a limit switch
`timescale 1ns/1ps
module pocu_field_model (
    input wire logic ref_clk,
    input wire logic clr,
    input wire logic [31:0] stop_at,
    input wire logic [3:0] pulse_out,
    output logic [3:0] limit_in,
    output logic [3:0][31:0] count_in
);
    // ----------------------------------------
    // Encoder and switch
    // ----------------------------------------
    logic [3:0] pulse_q; // Last pulse levels
    logic [31:0] count_q; // Rising edges on any channel
    // Count rising pulse edges; clr zeroes the shaft
    always_ff @(posedge ref_clk) begin
        pulse_q <= pulse_out;
        if (clr)
            count_q <= 32'h0;
        else
            count_q <= count_q + 32'(|(pulse_out & ~pulse_q));
    end
    // One shaft feeds every count source
    assign count_in = {4{count_q}};
    // Switch closes once travel reaches stop_at
    assign limit_in = {4{count_q >= stop_at}};
endmodule

/* test/pocu_top_tb.sv */
// Self-checking bench for the pulse output command unit
`timescale 1ns/1ps
module pocu_top_tb;
    import pocu_pkg::*;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [3:0] limit_in;
    logic [3:0] pulse_out;
    logic [3:0][31:0] count_in;
    logic clr = 1'b1; // Restart the encoder
    logic [31:0] stop_at = 32'hFFFF_FFFF; // Switch position
    logic [31:0] rd; // Last read data
    logic [31:0] lfsr = 32'hE5DC19AB;
    logic [31:0] p [6]; // Mirrored parameter words
    logic [7:0] ofs [6] = '{OFS_FREQ, OFS_DUTY, OFS_LIMIT, OFS_FUNC, OFS_POS, OFS_LCFG};
    int bad_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    int m_ret = 0; // Model of the retained code
    always #25 ref_clk = ~ref_clk;
    pocu_top #(.MODULE_NUM(8'h05)) pocu_top_inst (.ref_clk(ref_clk), .rstn(rstn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .limit_in(limit_in), .count_in(count_in), .pulse_out(pulse_out));
    pocu_field_model pocu_field_model_inst (.ref_clk(ref_clk), .clr(clr),
        .stop_at(stop_at), .pulse_out(pulse_out), .limit_in(limit_in), .count_in(count_in));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr_next(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // One word transfer; hready as sampled before the edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsel <= 1'b1;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // Expected outcome code from the mirrored parameters
    function automatic int exp_code(int c, logic [31:0] ck);
        if (ck[23:16] !== 8'h05)
            return 100;
        if (c == 0)
            return ck[24] ? 2001 : 0;
        if (p[0] < 20 || p[0] > 20000 || p[1] > 99)
            return 111;
        if (c == 1) begin
            if (p[2][3:0] > 3)
                return 107;
            if (p[2][7:4] > 2)
                return 105;
            return p[5][p[2][1:0]] ? 0 : 104;
        end
        if (p[3][7:4] > 1)
            return 106;
        if (p[3][3:0] > 3)
            return 107;
        return (p[4] > 32'd2147434528) ? 111 : 0;
    endfunction
    // Start a command on a fresh enable edge, check its outcome
    task automatic cmd(input int c, input logic [31:0] ck);
        int code = exp_code(c, ck);
        bus(1'b1, OFS_CTRL, ck);
        bus(1'b1, OFS_CTRL, ck | (32'h1 << c));
        repeat (8) @(posedge ref_clk);
        bus(1'b0, OFS_STAT, 32'h0);
        chk("status", {1'b0, code != 0, code == 0}, rd[3:1]);
        if (c == 0) begin
            bus(1'b0, OFS_RESULT, 32'h0);
            chk("result", ck[24] ? 2001 : m_ret, rd);
        end
        m_ret = code;
    endtask
    // Run must be active, then stop within bounded polls
    task automatic wait_stop();
        int n = 0;
        bus(1'b0, OFS_STAT, 32'h0);
        chk("running", 1'b1, rd[4]);
        while (rd[4] !== 1'b0 && n < 3000) begin
            bus(1'b0, OFS_STAT, 32'h0);
            n++;
        end
        chk("pulse_out", 4'h0, pulse_out);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count++;
            report_and_stop();
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        clr <= 1'b0;
        @(posedge ref_clk);
        bus(1'b0, OFS_FREQ, 32'h0);
        chk("freq", 32'h3E8, rd);
        bus(1'b1, OFS_RESULT, 32'hFFFF);
        bus(1'b0, OFS_RESULT, 32'h0);
        chk("result", 32'h0, rd);
        bus(1'b1, 8'h40, 32'h1);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        // Faulty command, then read-error twice
        for (int k = 0; k < 10; k++) begin
            p = '{32'd20000, 32'd0, 32'h0, 32'h10, 32'd2, 32'h1};
            case (k)
                1: p[0] = 32'd19;
                2: p[0] = 32'd20001;
                3: p[1] = 32'd100;
                4: p[2] = 32'h30;
                5: p[2] = 32'h04;
                6: p[5] = 32'h2;
                7: p[3] = 32'h20;
                8: p[3] = 32'h04;
                9: p[4] = 32'd2147434529;
                default: p[0] = 32'd1000;
            endcase
            foreach (p[i]) bus(1'b1, ofs[i], p[i]);
            cmd(k >= 7 ? 2 : 1, k == 0 ? 32'h0002_0000 : 32'h0005_0000);
            cmd(0, 32'h0005_0000);
            cmd(0, 32'h0005_0000);
        end
        cmd(0, 32'h0105_0000);
        cmd(0, 32'h0005_0000);
        // Run to a rising limit edge, random input and duty
        lfsr = lfsr_next(lfsr);
        p = '{32'd20000, lfsr % 100, {30'h0, lfsr[9:8]}, 32'h10, 32'd2, 32'hF};
        foreach (p[i]) bus(1'b1, ofs[i], p[i]);
        stop_at <= 32'd1 + lfsr % 3;
        cmd(1, 32'h0005_0200);
        wait_stop();
        chk("limit pulses", stop_at, count_in[0]);
        // Held enable rewritten: no restart
        bus(1'b1, OFS_CTRL, 32'h0005_0202);
        repeat (8) @(posedge ref_clk);
        bus(1'b0, OFS_STAT, 32'h0);
        chk("held", 32'h1, rd[4:1]);
        // Run to position: greater-than, random source and position
        clr <= 1'b1;
        stop_at <= 32'hFFFF_FFFF;
        @(posedge ref_clk);
        clr <= 1'b0;
        lfsr = lfsr_next(lfsr);
        p = '{32'd20000, lfsr % 100, 32'h0, {28'h1, 2'h0, lfsr[5:4]}, 32'd1 + lfsr % 3, 32'h0};
        foreach (p[i]) bus(1'b1, ofs[i], p[i]);
        cmd(2, 32'h0005_0100);
        wait_stop();
        chk("position pulses", p[4] + 32'd1, count_in[0]);
        report_and_stop();
    end
endmodule
